/* logic/ars_pkg.sv */
// Purpose: Shared constants for the alert recovery sequencer
// Assumes: 200 MHz node clock
// Notes: Alert type and code values are local encodings for the frame parser
package ars_pkg;

  // Clock rate and timing figures
  localparam int unsigned CLK_KHZ = 200000;
  localparam int unsigned MA_TMO_MS = 1000;
  localparam int unsigned RESEND_MS = 500;
  localparam int unsigned MA_TMO_CYC = MA_TMO_MS * CLK_KHZ;
  localparam int unsigned RESEND_CYC = RESEND_MS * CLK_KHZ;
  localparam int unsigned CW = 28;

  // Widths
  localparam int unsigned TAG_W = 16;
  localparam int unsigned PATH_W = 32;

  // Alert types
  localparam logic [3:0] T_ADDR = 4'h0;
  localparam logic [3:0] T_UNKNOWN = 4'h1;
  localparam logic [3:0] T_INVALID = 4'h2;
  localparam logic [3:0] T_PROTO = 4'h3;
  localparam logic [3:0] T_ENV = 4'h4;
  localparam logic [3:0] T_WARN = 4'h5;
  localparam logic [3:0] T_LINK_ERP = 4'h6;
  localparam logic [3:0] T_THRESH = 4'h7;
  localparam logic [3:0] T_MASTER_GEN = 4'h8;
  localparam logic [3:0] T_PNO = 4'h9;

  // Alert codes within a type
  localparam logic [7:0] C_NONE = 8'h00;
  localparam logic [7:0] C_PRIO_CHG = 8'h01;
  localparam logic [7:0] C_ULP_CHG = 8'h02;
  localparam logic [7:0] C_RESET_FAIL = 8'h01;
  localparam logic [7:0] C_TMO_READY = 8'h02;
  localparam logic [7:0] C_ALL_NORMAL = 8'h01;
  localparam logic [7:0] C_NODE_NORMAL = 8'h02;
  localparam logic [7:0] C_RECONFIG = 8'h03;
  localparam logic [7:0] C_BOTH_NORMAL = 8'h04;

  // Command operations, issued in ascending order within one alert
  localparam int unsigned NOPS = 27;
  localparam logic [4:0] OP_ASYNC_REPLY = 5'h00;
  localparam logic [4:0] OP_REPLY_INVALID = 5'h01;
  localparam logic [4:0] OP_CONFIG_WALK = 5'h02;
  localparam logic [4:0] OP_TERMINATE_IO = 5'h03;
  localparam logic [4:0] OP_INVAL_CFG = 5'h04;
  localparam logic [4:0] OP_STOP_OUTBOUND = 5'h05;
  localparam logic [4:0] OP_QUIESCE_AFF = 5'h06;
  localparam logic [4:0] OP_ULP_ALL_NORMAL = 5'h07;
  localparam logic [4:0] OP_CLEAR_RECONF = 5'h08;
  localparam logic [4:0] OP_PATH_NORMAL = 5'h09;
  localparam logic [4:0] OP_VENDOR_ERR = 5'h0a;
  localparam logic [4:0] OP_QUERY_PROTO = 5'h0b;
  localparam logic [4:0] OP_RESPONSE = 5'h0c;
  localparam logic [4:0] OP_MA_FWD = 5'h0d;
  localparam logic [4:0] OP_LOG = 5'h0e;
  localparam logic [4:0] OP_MA_WAIT = 5'h0f;
  localparam logic [4:0] OP_TOTAL_RESET = 5'h10;
  localparam logic [4:0] OP_INVAL_LINK = 5'h11;
  localparam logic [4:0] OP_INVAL_NODE = 5'h12;
  localparam logic [4:0] OP_QUIESCE_REMOVE_CONFIGUTOR_ENTRY_BIT = 5'h13;
  localparam logic [4:0] OP_QUERY_NODE = 5'h14;
  localparam logic [4:0] OP_CONFIG_PORT = 5'h15;
  localparam logic [4:0] OP_MA_BOTH = 5'h16;
  localparam logic [4:0] OP_BOTH_WAIT = 5'h17;
  localparam logic [4:0] OP_QUERY_REBUILD = 5'h18;
  localparam logic [4:0] OP_REISSUE = 5'h19;
  localparam logic [4:0] OP_WEB_RESET = 5'h1a;

  // Sequencer states
  typedef enum logic [3:0]
  {
    ST_IDLE = 4'h1,
    ST_ISSUE = 4'h2,
    ST_DONE = 4'h4,
    ST_RSP = 4'h8
  } ars_state_t;

endpackage

/* logic/ars_alert_sequencer.sv */
// Purpose: Alert recovery sequencer for Master and Configutor roles of a web node
// Assumes: Frame engine executes each command and reports completion on cmd_done_i
// Notes: One alert is handled at a time; commands leave in a fixed ascending order
// Operation
// (RULE1) A newly connected link sets the operational flag and raises an own alert.
// (RULE2) Master walks the new link with node queries; queried nodes reply.
// (RULE3) Master sets operational new ports to normal mode and gets responses.
// (RULE4) Master forwards both-ports-normal, or all-normal when the web is a loop.
// (RULE5) Further port-now-operational alerts wait until the current handling ends.
// (RULE6) Configutor may query node and protocol on protocol-list warnings, or discard.
// (RULE7) Master forwards other warnings to every Configutor.
// (RULE8) Master sends Total Reset for reset-failed or ready-timeout link exits.
// (RULE9) Master invalidates link entries, and node entries for a reset node.
// (RULE10) Master quiesces remaining nodes with remove bit for a lost Configutor.
// (RULE11) Master renormalises a still configured link and forwards both-normal; the code forwards all-normal instead when the web is a loop.
// (RULE12) Master-generated alerts get an invalid-field reply, a log and no forward.
// (RULE13) Configutor answers each master alert by tag over its return path, then logs.
// (RULE14) Error-class master alerts trigger vendor error handling.
// (RULE15) Configutor walks from the reported port before the general handling.
// (RULE16) Address error: terminate I/O, invalidate, respond, reissue on alternate path.
// (RULE17) Link exit: invalidate, stop outbound transfers, quiesce affected nodes.
// (RULE18) Configutor response waits until every quiesce has been answered.
// (RULE19) After quiescing, requery nodes and reissue commands when a path remains.
// (RULE20) All-normal alert tells upper protocols, then general handling.
// (RULE21) Reconfiguration-required clears the table and reconfigures, then general.
// (RULE22) Node-ready is withheld until every port on its path is normal.
// (RULE23) Missing Configutor responses within one second start a web reset.
// (RULE24) Own alert resends every 500 ms until matched reply or port reset.
// (RULE25) Master handles alerts one at a time in arrival order.
`timescale 1ns/1ps

module ars_alert_sequencer #(
  parameter int unsigned MA_TMO_CYC = ars_pkg::MA_TMO_CYC,
  parameter int unsigned RESEND_CYC = ars_pkg::RESEND_CYC,
  parameter int unsigned TAG_W = ars_pkg::TAG_W,
  parameter int unsigned PATH_W = ars_pkg::PATH_W
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Role and web state
  input wire logic master_role_i,
  input wire logic web_loop_i,
  // Received asynchronous alert (Master role)
  input wire logic aa_valid_i,
  input wire logic [3:0] aa_type_i,
  input wire logic [7:0] aa_code_i,
  input wire logic [TAG_W-1:0] aa_tag_i,
  input wire logic [7:0] aa_port_i,
  input wire logic [PATH_W-1:0] aa_path_i,
  input wire logic aa_cfg_lost_i,
  input wire logic aa_link_cfg_i,
  output logic aa_ready_o,
  // Received master alert (Configutor role)
  input wire logic ma_valid_i,
  input wire logic [3:0] ma_type_i,
  input wire logic [7:0] ma_code_i,
  input wire logic [TAG_W-1:0] ma_tag_i,
  input wire logic [7:0] ma_port_i,
  input wire logic [PATH_W-1:0] ma_path_i,
  input wire logic ma_alt_path_i,
  input wire logic ma_need_info_i,
  output logic ma_ready_o,
  // Command to the frame engine
  output logic cmd_valid_o,
  output logic [4:0] cmd_op_o,
  output logic [3:0] cmd_type_o,
  output logic [7:0] cmd_code_o,
  output logic [TAG_W-1:0] cmd_tag_o,
  output logic [7:0] cmd_port_o,
  output logic [PATH_W-1:0] cmd_path_o,
  output logic cmd_rc_invalid_o,
  output logic cmd_remove_configutor_entry_bit_o,
  input wire logic cmd_ready_i,
  input wire logic cmd_done_i,
  input wire logic rsp_all_i,
  // Own port alert
  input wire logic port_up_i,
  input wire logic port_reset_i,
  input wire logic [TAG_W-1:0] own_tag_i,
  input wire logic own_reply_i,
  input wire logic [TAG_W-1:0] own_reply_tag_i,
  input wire logic [3:0] own_reply_type_i,
  output logic oper_flag_o,
  output logic own_aa_send_o
);

  localparam int unsigned CW = ars_pkg::CW;
  localparam int unsigned NOPS = ars_pkg::NOPS;

  // Refuse timings the counters cannot hold
  if (MA_TMO_CYC < 2 || RESEND_CYC < 2 || MA_TMO_CYC >= (2**CW) || RESEND_CYC >= (2**CW))
  begin : g_bad_cnt
    $error("Timing count out of counter range");
  end
  if (TAG_W < 1 || PATH_W < 1)
  begin : g_bad_w
    $error("Tag and path widths must be positive");
  end

  // Lowest pending operation is the next one
  function automatic logic [4:0] first_op(input logic [NOPS-1:0] m);
    logic [4:0] r;
    r = 5'h00;
    for (int i = NOPS - 1; i >= 0; i--)
    begin
      if (m[i])
      begin
        r = 5'(i);
      end
    end
    return r;
  endfunction

  function automatic logic is_wait(input logic [4:0] op);
    return (op == ars_pkg::OP_MA_WAIT) || (op == ars_pkg::OP_BOTH_WAIT);
  endfunction

  // Sequence for an asynchronous alert received as Master
  function automatic logic [NOPS-1:0] master_mask(input logic [3:0] t, input logic [7:0] c,
                                                  input logic lost, input logic lcfg);
    logic [NOPS-1:0] m;
    m = '0;
    if (t == ars_pkg::T_MASTER_GEN)
    begin
      m[ars_pkg::OP_REPLY_INVALID] = 1'b1; // RULE12
      m[ars_pkg::OP_LOG] = 1'b1; // RULE12
    end
    else
    begin
      m[ars_pkg::OP_ASYNC_REPLY] = 1'b1;
      if (!(t == ars_pkg::T_WARN && c == ars_pkg::C_PRIO_CHG))
      begin
        m[ars_pkg::OP_MA_FWD] = 1'b1; // RULE7
        m[ars_pkg::OP_LOG] = 1'b1;
        m[ars_pkg::OP_MA_WAIT] = 1'b1; // RULE23
      end
      if (t == ars_pkg::T_PNO)
      begin
        m[ars_pkg::OP_QUERY_NODE] = 1'b1; // RULE2
        m[ars_pkg::OP_CONFIG_PORT] = 1'b1; // RULE3
        m[ars_pkg::OP_MA_BOTH] = 1'b1; // RULE4
        m[ars_pkg::OP_BOTH_WAIT] = 1'b1; // RULE5
      end
      if (t == ars_pkg::T_LINK_ERP)
      begin
        m[ars_pkg::OP_INVAL_LINK] = 1'b1; // RULE9
        if (c == ars_pkg::C_RESET_FAIL || c == ars_pkg::C_TMO_READY)
        begin
          m[ars_pkg::OP_TOTAL_RESET] = 1'b1; // RULE8
          m[ars_pkg::OP_INVAL_NODE] = 1'b1; // RULE9
        end
        m[ars_pkg::OP_QUIESCE_REMOVE_CONFIGUTOR_ENTRY_BIT] = lost; // RULE10
        m[ars_pkg::OP_CONFIG_PORT] = lcfg; // RULE11
        m[ars_pkg::OP_MA_BOTH] = lcfg; // RULE11
        m[ars_pkg::OP_BOTH_WAIT] = lcfg; // RULE11
      end
    end
    return m;
  endfunction

  // Sequence for a master alert received as Configutor
  function automatic logic [NOPS-1:0] cfg_mask(input logic [3:0] t, input logic [7:0] c,
                                               input logic alt, input logic need);
    logic [NOPS-1:0] m;
    m = '0;
    m[ars_pkg::OP_RESPONSE] = 1'b1; // RULE13
    m[ars_pkg::OP_LOG] = 1'b1; // RULE13
    unique case (t)
      ars_pkg::T_PNO:
        m[ars_pkg::OP_CONFIG_WALK] = 1'b1; // RULE15
      ars_pkg::T_ADDR:
      begin
        m[ars_pkg::OP_TERMINATE_IO] = 1'b1; // RULE16
        m[ars_pkg::OP_INVAL_CFG] = 1'b1; // RULE16
        m[ars_pkg::OP_REISSUE] = alt; // RULE16
      end
      ars_pkg::T_LINK_ERP:
      begin
        m[ars_pkg::OP_INVAL_CFG] = 1'b1; // RULE17
        m[ars_pkg::OP_STOP_OUTBOUND] = 1'b1; // RULE17
        m[ars_pkg::OP_QUIESCE_AFF] = 1'b1; // RULE17
        m[ars_pkg::OP_QUERY_REBUILD] = 1'b1; // RULE19
        m[ars_pkg::OP_REISSUE] = alt; // RULE19
      end
      ars_pkg::T_WARN:
      begin
        if (c == ars_pkg::C_ULP_CHG)
        begin
          m[ars_pkg::OP_QUERY_PROTO] = need; // RULE6
        end
        else
        begin
          m[ars_pkg::OP_VENDOR_ERR] = 1'b1; // RULE14
        end
      end
      ars_pkg::T_MASTER_GEN:
      begin
        m[ars_pkg::OP_ULP_ALL_NORMAL] = (c == ars_pkg::C_ALL_NORMAL); // RULE20
        m[ars_pkg::OP_CLEAR_RECONF] = (c == ars_pkg::C_RECONFIG); // RULE21
        m[ars_pkg::OP_PATH_NORMAL] = (c == ars_pkg::C_NODE_NORMAL) ||
                                     (c == ars_pkg::C_BOTH_NORMAL); // RULE22
      end
      default:
        m[ars_pkg::OP_VENDOR_ERR] = 1'b1; // RULE14
    endcase
    return m;
  endfunction

  ars_pkg::ars_state_t state_ff;
  ars_pkg::ars_state_t nxt_state;
  logic [NOPS-1:0] mask_ff;
  logic [NOPS-1:0] nxt_mask;
  logic [CW-1:0] tmr_ff;
  logic [CW-1:0] nxt_tmr;
  logic launch;
  logic [4:0] nxt_op;
  logic aa_rdy_ff;
  logic ma_rdy_ff;
  logic [3:0] a_type_ff;
  logic [7:0] a_code_ff;
  logic [TAG_W-1:0] a_tag_ff;
  logic [7:0] a_port_ff;
  logic [PATH_W-1:0] a_path_ff;
  logic cmd_valid_ff;
  logic [4:0] cmd_op_ff;
  logic [3:0] cmd_type_ff;
  logic [7:0] cmd_code_ff;
  logic cmd_rc_ff;
  logic cmd_remove_configutor_entry_bit_ff;

  // Only an idle sequencer takes a new alert, so alerts are served in arrival order
  wire take_aa = aa_valid_i && aa_rdy_ff; // RULE25
  wire take_ma = ma_valid_i && ma_rdy_ff;
  wire [4:0] cur_op = first_op(mask_ff);
  wire [NOPS-1:0] cur_bit = NOPS'(1) << cur_op;
  wire tmo_hit = (tmr_ff == CW'(MA_TMO_CYC - 1));

  // Sequencer next state
  always_comb
  begin
    nxt_state = state_ff;
    nxt_mask = mask_ff;
    nxt_tmr = tmr_ff;
    launch = 1'b0;
    unique case (state_ff)
      ars_pkg::ST_IDLE:
      begin
        if (take_aa)
        begin
          nxt_mask = master_mask(aa_type_i, aa_code_i, aa_cfg_lost_i, aa_link_cfg_i);
          launch = 1'b1;
        end
        else if (take_ma)
        begin
          nxt_mask = cfg_mask(ma_type_i, ma_code_i, ma_alt_path_i, ma_need_info_i);
          launch = 1'b1;
        end
      end
      ars_pkg::ST_ISSUE:
      begin
        if (cmd_ready_i)
        begin
          nxt_state = ars_pkg::ST_DONE;
        end
      end
      ars_pkg::ST_DONE:
      begin
        // Quiesce completion is reported only once every quiesced node has answered
        if (cmd_done_i)
        begin
          nxt_mask = mask_ff & ~cur_bit; // RULE18
          launch = 1'b1;
        end
      end
      ars_pkg::ST_RSP:
      begin
        if (rsp_all_i)
        begin
          nxt_mask = mask_ff & ~cur_bit;
          launch = 1'b1;
        end
        else if (tmo_hit)
        begin
          nxt_mask = NOPS'(1) << ars_pkg::OP_WEB_RESET; // RULE23
          launch = 1'b1;
        end
        else
        begin
          nxt_tmr = tmr_ff + CW'(1);
        end
      end
      default:
      begin
        nxt_state = ars_pkg::ST_IDLE;
        nxt_mask = '0;
      end
    endcase
    nxt_op = first_op(nxt_mask);
    if (launch)
    begin
      nxt_tmr = '0;
      if (nxt_mask == '0)
      begin
        nxt_state = ars_pkg::ST_IDLE;
      end
      else if (is_wait(nxt_op))
      begin
        nxt_state = ars_pkg::ST_RSP;
      end
      else
      begin
        nxt_state = ars_pkg::ST_ISSUE;
      end
    end
  end

  // Command fields for the operation being launched
  wire nxt_is_issue = launch && (nxt_state == ars_pkg::ST_ISSUE);
  wire nxt_both = (nxt_op == ars_pkg::OP_MA_BOTH);
  wire [7:0] both_code = web_loop_i ? ars_pkg::C_ALL_NORMAL : ars_pkg::C_BOTH_NORMAL; // RULE4
  wire [3:0] nxt_type = nxt_both ? ars_pkg::T_MASTER_GEN : (take_aa ? aa_type_i :
                        (take_ma ? ma_type_i : a_type_ff));
  wire [7:0] nxt_code = nxt_both ? both_code : (take_aa ? aa_code_i :
                        (take_ma ? ma_code_i : a_code_ff));

  // State and operation registers
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      state_ff <= ars_pkg::ST_IDLE;
      mask_ff <= '0;
      tmr_ff <= '0;
      aa_rdy_ff <= 1'b0;
      ma_rdy_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      mask_ff <= nxt_mask;
      tmr_ff <= nxt_tmr;
      aa_rdy_ff <= (nxt_state == ars_pkg::ST_IDLE) && master_role_i; // RULE5
      ma_rdy_ff <= (nxt_state == ars_pkg::ST_IDLE) && !master_role_i;
    end
  end

  // Latched alert context; tag and path travel with every command of the sequence
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      a_type_ff <= 4'h0;
      a_code_ff <= 8'h00;
      a_tag_ff <= '0;
      a_port_ff <= 8'h00;
      a_path_ff <= '0;
    end
    else if (take_aa)
    begin
      a_type_ff <= aa_type_i;
      a_code_ff <= aa_code_i;
      a_tag_ff <= aa_tag_i;
      a_port_ff <= aa_port_i;
      a_path_ff <= aa_path_i;
    end
    else if (take_ma)
    begin
      a_type_ff <= ma_type_i;
      a_code_ff <= ma_code_i;
      a_tag_ff <= ma_tag_i; // RULE13
      a_port_ff <= ma_port_i; // RULE15
      a_path_ff <= ma_path_i; // RULE13
    end
  end

  // Command register toward the frame engine
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      cmd_valid_ff <= 1'b0;
      cmd_op_ff <= 5'h00;
      cmd_type_ff <= 4'h0;
      cmd_code_ff <= 8'h00;
      cmd_rc_ff <= 1'b0;
      cmd_remove_configutor_entry_bit_ff <= 1'b0;
    end
    else if (launch)
    begin
      cmd_valid_ff <= nxt_is_issue;
      cmd_op_ff <= nxt_op;
      cmd_type_ff <= nxt_type;
      cmd_code_ff <= nxt_code;
      cmd_rc_ff <= (nxt_op == ars_pkg::OP_REPLY_INVALID); // RULE12
      cmd_remove_configutor_entry_bit_ff <= (nxt_op == ars_pkg::OP_QUIESCE_REMOVE_CONFIGUTOR_ENTRY_BIT); // RULE10
    end
    else if (cmd_ready_i)
    begin
      cmd_valid_ff <= 1'b0;
    end
  end

  // Own port alert with periodic resend; a new link event wins over a clear
  logic oper_ff;
  logic pend_ff;
  logic send_ff;
  logic [CW-1:0] rs_cnt_ff;
  wire rs_hit = pend_ff && (rs_cnt_ff == CW'(RESEND_CYC - 1));
  wire reply_ok = own_reply_i && (own_reply_tag_i == own_tag_i) &&
                  (own_reply_type_i == ars_pkg::T_PNO);

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      oper_ff <= 1'b0;
      pend_ff <= 1'b0;
      send_ff <= 1'b0;
      rs_cnt_ff <= '0;
    end
    else
    begin
      oper_ff <= port_up_i || (oper_ff && !port_reset_i); // RULE1
      pend_ff <= port_up_i || (pend_ff && !reply_ok && !port_reset_i); // RULE24
      send_ff <= port_up_i || (rs_hit && !reply_ok && !port_reset_i); // RULE24
      rs_cnt_ff <= (port_up_i || rs_hit || !pend_ff) ? '0 : rs_cnt_ff + CW'(1);
    end
  end

  assign aa_ready_o = aa_rdy_ff;
  assign ma_ready_o = ma_rdy_ff;
  assign cmd_valid_o = cmd_valid_ff;
  assign cmd_op_o = cmd_op_ff;
  assign cmd_type_o = cmd_type_ff;
  assign cmd_code_o = cmd_code_ff;
  assign cmd_tag_o = a_tag_ff;
  assign cmd_port_o = a_port_ff;
  assign cmd_path_o = a_path_ff;
  assign cmd_rc_invalid_o = cmd_rc_ff;
  assign cmd_remove_configutor_entry_bit_o = cmd_remove_configutor_entry_bit_ff;
  assign oper_flag_o = oper_ff;
  assign own_aa_send_o = send_ff;

  // Cycles since the last own alert, saturating, for the resend check
  logic [CW-1:0] gap_ff;
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      gap_ff <= '0;
    end
    else
    begin
      gap_ff <= send_ff ? CW'(1) : ((&gap_ff) ? gap_ff : gap_ff + CW'(1));
    end
  end

  a_link_up_flag: assert property ( // RULE1
    @(posedge clk_i) disable iff (sys_rst_i)
    port_up_i |=> oper_flag_o && own_aa_send_o)
    else $error("New link did not raise flag and alert");

  a_resend_gap: assert property ( // RULE24
    @(posedge clk_i) disable iff (sys_rst_i)
    (own_aa_send_o && !$past(port_up_i)) |-> (gap_ff == CW'(RESEND_CYC)))
    else $error("Own alert resent at wrong spacing");

  a_busy_refuse: assert property ( // RULE25
    @(posedge clk_i) disable iff (sys_rst_i)
    (state_ff != ars_pkg::ST_IDLE) |-> !aa_ready_o && !ma_ready_o)
    else $error("Alert accepted while busy");

  a_pno_steps: assert property ( // RULE2
    @(posedge clk_i) disable iff (sys_rst_i)
    (take_aa && aa_type_i == ars_pkg::T_PNO) |=>
      mask_ff[ars_pkg::OP_QUERY_NODE] && mask_ff[ars_pkg::OP_CONFIG_PORT] &&
      mask_ff[ars_pkg::OP_MA_BOTH] && mask_ff[ars_pkg::OP_BOTH_WAIT])
    else $error("Link walk steps missing");

  a_reset_failing: assert property ( // RULE8
    @(posedge clk_i) disable iff (sys_rst_i)
    (take_aa && aa_type_i == ars_pkg::T_LINK_ERP && aa_code_i == ars_pkg::C_RESET_FAIL) |=>
      mask_ff[ars_pkg::OP_TOTAL_RESET] && mask_ff[ars_pkg::OP_INVAL_NODE] &&
      mask_ff[ars_pkg::OP_INVAL_LINK])
    else $error("Total reset or invalidation missing");

  a_mg_no_fwd: assert property ( // RULE12
    @(posedge clk_i) disable iff (sys_rst_i)
    (take_aa && aa_type_i == ars_pkg::T_MASTER_GEN) |=>
      mask_ff[ars_pkg::OP_REPLY_INVALID] && !mask_ff[ars_pkg::OP_MA_FWD] &&
      !mask_ff[ars_pkg::OP_ASYNC_REPLY])
    else $error("Master-generated alert handled wrongly");

  a_cfg_respond: assert property ( // RULE13
    @(posedge clk_i) disable iff (sys_rst_i)
    take_ma |=> mask_ff[ars_pkg::OP_RESPONSE] && (cmd_tag_o == $past(ma_tag_i)))
    else $error("Master alert not answered by tag");

  a_rsp_after_quiesce: assert property ( // RULE18
    @(posedge clk_i) disable iff (sys_rst_i)
    (cmd_valid_o && cmd_op_o == ars_pkg::OP_RESPONSE) |-> !mask_ff[ars_pkg::OP_QUIESCE_AFF])
    else $error("Response sent before quiesce done");

  a_ma_timeout: assert property ( // RULE23
    @(posedge clk_i) disable iff (sys_rst_i)
    (state_ff == ars_pkg::ST_RSP && tmo_hit && !rsp_all_i) |=>
      cmd_valid_o && (cmd_op_o == ars_pkg::OP_WEB_RESET))
    else $error("Web reset not started on timeout");

  a_remove_configutor_entry_bit_bit: assert property ( // RULE10
    @(posedge clk_i) disable iff (sys_rst_i)
    (cmd_valid_o && cmd_op_o == ars_pkg::OP_QUIESCE_REMOVE_CONFIGUTOR_ENTRY_BIT) |-> cmd_remove_configutor_entry_bit_o && !cmd_rc_invalid_o)
    else $error("Remove bit missing on quiesce");

endmodule // ars_alert_sequencer

/* sim/ars_engine_model.sv */
// Purpose: Frame engine stand-in facing the alert sequencer command port
// Assumes: One command in flight at a time
// Notes: Done means every addressed node has replied; slow mode stretches replies
`timescale 1ns/1ps

module ars_engine_model (
  // Clock, reset and pace
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic slow_i,
  // Command handshake
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  output logic cmd_done_o
);
  logic [2:0] wait_ff;

  // Accept a cycle after valid; replies return two or five cycles after acceptance
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      cmd_ready_o <= 1'b0;
      cmd_done_o <= 1'b0;
      wait_ff <= 3'h0;
    end
    else
    begin
      cmd_ready_o <= cmd_valid_i && !cmd_ready_o && (wait_ff == 3'h0);
      cmd_done_o <= (wait_ff == 3'h1);
      if (cmd_ready_o && cmd_valid_i)
        wait_ff <= slow_i ? 3'h4 : 3'h1;
      else if (wait_ff != 3'h0)
        wait_ff <= wait_ff - 3'h1;
    end
  end
endmodule // ars_engine_model

/* sim/ars_alert_sequencer_tb_top.sv */
// Purpose: Self-checking bench for the alert sequencer
// Assumes: Short timeout and resend counts so the run stays brief
// Notes: Commands are logged at acceptance and compared in issue order
`timescale 1ns/1ps

module ars_alert_sequencer_tb_top;
  localparam int unsigned RSND = 30;
  logic clk_i = 1'b0, sys_rst_i = 1'b1, role = 1'b0, loop = 1'b0, av = 1'b0, mv = 1'b0;
  logic lost = 1'b0, lcfg = 1'b0, alt = 1'b0, slow = 1'b0, rsp_all = 1'b1;
  logic up = 1'b0, prst = 1'b0, rep = 1'b0;
  logic [3:0] f_type = 4'h0, rep_type = ars_pkg::T_PNO, c_type;
  logic [7:0] f_code = 8'h00, c_code, c_port, rsp_port;
  logic [11:0] both_code;
  logic [31:0] c_path, rsp_path;
  logic [15:0] f_tag = 16'h0000, rep_tag = 16'h0000, rsp_tag, c_tag;
  logic aa_rdy, ma_rdy, c_val, c_rdy, c_done, rcinv, remove_configutor_entry_bit, oper, send;
  logic [4:0] c_op;
  logic [6:0] ops[$];
  int fails = 0, check_count = 0, sends = 0;

  ars_alert_sequencer #(.MA_TMO_CYC(20), .RESEND_CYC(RSND)) DUT (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .master_role_i(role), .web_loop_i(loop),
    .aa_valid_i(av), .aa_type_i(f_type), .aa_code_i(f_code), .aa_tag_i(f_tag),
    .aa_port_i(f_tag[7:0]), .aa_path_i({2{f_tag}}), .aa_cfg_lost_i(lost),
    .aa_link_cfg_i(lcfg), .aa_ready_o(aa_rdy), .ma_valid_i(mv), .ma_type_i(f_type),
    .ma_code_i(f_code), .ma_tag_i(f_tag), .ma_port_i(f_tag[7:0]), .ma_path_i({2{f_tag}}),
    .ma_alt_path_i(alt), .ma_need_info_i(alt), .ma_ready_o(ma_rdy), .cmd_valid_o(c_val),
    .cmd_op_o(c_op), .cmd_type_o(c_type), .cmd_code_o(c_code), .cmd_tag_o(c_tag),
    .cmd_port_o(c_port),
    .cmd_path_o(c_path), .cmd_rc_invalid_o(rcinv), .cmd_remove_configutor_entry_bit_o(remove_configutor_entry_bit), .cmd_ready_i(c_rdy),
    .cmd_done_i(c_done), .rsp_all_i(rsp_all), .port_up_i(up), .port_reset_i(prst),
    .own_tag_i(16'h5a5a), .own_reply_i(rep), .own_reply_tag_i(rep_tag),
    .own_reply_type_i(rep_type), .oper_flag_o(oper), .own_aa_send_o(send));

  ars_engine_model u_eng (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .slow_i(slow),
    .cmd_valid_i(c_val), .cmd_ready_o(c_rdy), .cmd_done_o(c_done));

  // Free-running node clock
  initial forever #2.5 clk_i = ~clk_i;

  // Log each accepted command and count own alert sends
  always @(posedge clk_i)
  begin
    if (c_val && c_rdy)
      ops.push_back({remove_configutor_entry_bit, rcinv, c_op});
    if (c_val && c_rdy && c_op == ars_pkg::OP_MA_BOTH)
      both_code = {c_type, c_code};
    if (c_val && c_rdy && c_op == ars_pkg::OP_RESPONSE)
      {rsp_tag, rsp_port, rsp_path} = {c_tag, c_port, c_path};
    if (send)
      sends++;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Polled at the falling edge so registered readiness is settled
  task automatic wrdy(input logic m);
    @(negedge clk_i);
    for (int n = 0; n < 400 && (m ? aa_rdy : ma_rdy) !== 1'b1; n++)
      @(negedge clk_i);
    chk(m ? aa_rdy : ma_rdy, 1'b1);
  endtask

  // Offer one alert, wait for the sequence to end, compare the command list
  task automatic run(input logic m, input logic [3:0] t, input logic [7:0] c,
                     input logic [6:0] e[$]);
    @(posedge clk_i);
    ops.delete();
    f_type <= t;
    f_code <= c;
    f_tag <= f_tag + 16'h0111;
    av <= m;
    mv <= !m;
    wrdy(m);
    @(posedge clk_i);
    av <= 1'b0;
    mv <= 1'b0;
    repeat (3) @(negedge clk_i);
    wrdy(m);
    chk(ops.size(), e.size());
    foreach (e[i]) chk(ops[i], e[i]);
  endtask

  task automatic t_cfg();
    run(1'b0, ars_pkg::T_UNKNOWN, ars_pkg::C_NONE, '{7'h0a, 7'h0c, 7'h0e});
    chk(rsp_tag, f_tag);
    chk(rsp_path, {2{f_tag}});
    run(1'b0, ars_pkg::T_MASTER_GEN, ars_pkg::C_ALL_NORMAL, '{7'h07, 7'h0c, 7'h0e});
    // Slow replies make the response wait on every quiesce
    @(posedge clk_i);
    alt <= 1'b1;
    slow <= 1'b1;
    run(1'b0, ars_pkg::T_LINK_ERP, ars_pkg::C_NONE,
        '{7'h04, 7'h05, 7'h06, 7'h0c, 7'h0e, 7'h18, 7'h19});
    run(1'b0, ars_pkg::T_ADDR, ars_pkg::C_NONE, '{7'h03, 7'h04, 7'h0c, 7'h0e, 7'h19});
    run(1'b0, ars_pkg::T_WARN, ars_pkg::C_ULP_CHG, '{7'h0b, 7'h0c, 7'h0e});
    run(1'b0, ars_pkg::T_PNO, ars_pkg::C_NONE, '{7'h02, 7'h0c, 7'h0e});
    chk(rsp_port, f_tag[7:0]);
    run(1'b0, ars_pkg::T_MASTER_GEN, ars_pkg::C_RECONFIG, '{7'h08, 7'h0c, 7'h0e});
    run(1'b0, ars_pkg::T_MASTER_GEN, ars_pkg::C_BOTH_NORMAL, '{7'h09, 7'h0c, 7'h0e});
  endtask

  task automatic t_mst();
    @(posedge clk_i);
    role <= 1'b1;
    slow <= 1'b0;
    run(1'b1, ars_pkg::T_MASTER_GEN, ars_pkg::C_NONE, '{7'h21, 7'h0e});
    @(posedge clk_i);
    lost <= 1'b1;
    lcfg <= 1'b1;
    run(1'b1, ars_pkg::T_LINK_ERP, ars_pkg::C_RESET_FAIL, '{7'h00, 7'h0d, 7'h0e, 7'h10,
        7'h11, 7'h12, 7'h53, 7'h15, 7'h16});
    chk(both_code, {ars_pkg::T_MASTER_GEN, ars_pkg::C_BOTH_NORMAL});
    @(posedge clk_i);
    loop <= 1'b1;
    run(1'b1, ars_pkg::T_PNO, ars_pkg::C_NONE,
        '{7'h00, 7'h0d, 7'h0e, 7'h14, 7'h15, 7'h16});
    chk(both_code, {ars_pkg::T_MASTER_GEN, ars_pkg::C_ALL_NORMAL});
    run(1'b1, ars_pkg::T_WARN, ars_pkg::C_PRIO_CHG, '{7'h00});
    // Silent Configutors must end in a web reset
    @(posedge clk_i);
    rsp_all <= 1'b0;
    run(1'b1, ars_pkg::T_ENV, ars_pkg::C_NONE, '{7'h00, 7'h0d, 7'h0e, 7'h1a});
  endtask

  task automatic t_own();
    @(posedge clk_i);
    up <= 1'b1;
    @(posedge clk_i);
    up <= 1'b0;
    rep <= 1'b1;
    rep_tag <= 16'h0bad;
    @(posedge clk_i);
    // Right tag but wrong type must be ignored as well
    rep_tag <= 16'h5a5a;
    rep_type <= ars_pkg::T_WARN;
    @(posedge clk_i);
    rep <= 1'b0;
    rep_type <= ars_pkg::T_PNO;
    repeat (2 * RSND + 3) @(posedge clk_i);
    @(negedge clk_i);
    chk(sends, 3);
    chk(oper, 1'b1);
    @(posedge clk_i);
    rep <= 1'b1;
    rep_tag <= 16'h5a5a;
    @(posedge clk_i);
    rep <= 1'b0;
    repeat (RSND + 5) @(posedge clk_i);
    prst <= 1'b1;
    @(posedge clk_i);
    prst <= 1'b0;
    @(negedge clk_i);
    chk(sends, 3);
    chk(oper, 1'b0);
  endtask

  task automatic test_done();
    if (fails == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Whole run needs about five hundred cycles
  initial
  begin
    repeat (5000) @(posedge clk_i);
    fails++;
    test_done();
  end

  initial
  begin
    repeat (5) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    t_cfg();
    t_mst();
    t_own();
    test_done();
  end
endmodule // ars_alert_sequencer_tb_top
